// *** hw/pp_pkg.sv ***
// Constants, types and register map of the parallel host port.
// Assumes a single 100 MHz core clock.
package pp_pkg;

  localparam int CLK_MHZ      = 100;

  localparam int C_SETUP_NS   = 500;
  localparam int C_STROBE_NS  = 500;
  localparam int C_HOLD_NS    = 500;
  localparam int E_SETUP_NS   = 50;
  localparam int E_TIMEOUT_NS = 10000;

  localparam logic [9:0] C_SETUP_CYC   = 10'((C_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] C_STROBE_CYC  = 10'((C_STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] C_HOLD_CYC    = 10'((C_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] E_SETUP_CYC   = 10'((E_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] E_TIMEOUT_CYC = 10'((E_TIMEOUT_NS * CLK_MHZ) / 1000);

  localparam logic [7:0] REG_DATA     = 8'h00;
  localparam logic [7:0] REG_PINS     = 8'h04;
  localparam logic [7:0] REG_CTRL     = 8'h08;
  localparam logic [7:0] REG_EPP_ADDR = 8'h0c;
  localparam logic [7:0] REG_EPP_DATA = 8'h10;
  localparam logic [7:0] REG_EPP_RD   = 8'h14;
  localparam logic [7:0] REG_IRQ_ST   = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;

  localparam int CTRL_STB   = 0;
  localparam int CTRL_LF    = 1;
  localparam int CTRL_INIT  = 2;
  localparam int CTRL_SEL   = 3;
  localparam int CTRL_DIR   = 4;
  localparam int CTRL_EPP   = 5;
  localparam int CTRL_AUTO  = 6;
  localparam int CTRL_ABORT = 7;
  localparam logic [7:0] CTRL_RST = 8'h04;

  localparam int IRQ_ACK   = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_TX    = 2;
  localparam int IRQ_EDONE = 3;
  localparam int IRQ_ETO   = 4;
  localparam int IRQ_W     = 5;

  localparam int PINS_W = 13;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_C_SETUP  = 3'b001,
    S_C_STROBE = 3'b010,
    S_C_HOLD   = 3'b011,
    S_E_SETUP  = 3'b100,
    S_E_STROBE = 3'b101
  } pp_fsm_t;

  typedef struct packed {
    logic [7:0] lines;
    logic       online;
    logic       paper_out;
    logic       err_n;
    logic       busy_wait;
    logic       ack_n;
  } pp_pins_t;

  typedef struct packed {
    pp_fsm_t          st;
    logic [9:0]       cnt;
    logic [7:0]       ctrl;
    logic [7:0]       dout;
    logic [7:0]       pend;
    logic             pend_v;
    logic [7:0]       epp_rd;
    logic             epp_addr;
    logic             epp_wr;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0]       rdata;
    logic             ack_prev;
    logic             err_prev;
  } pp_regs_t;

endpackage

// *** hw/pp_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module pp_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [2*W-1:0] sync_q;
  logic [2*W-1:0] sync_d;

  always_comb begin
    sync_d = {sync_q[W-1:0], din};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q[2*W-1:W];

endmodule
`default_nettype wire

// *** hw/pp_port.sv ***
// Host parallel port: compatibility and EPP pin protocol with a register port.
// Assumes a single core clock; all printer pins are asynchronous.
//
// Behaviour
// - Line feed driven low, released when bit 0.
// - Data strobe low in data cycle, high on abort.
// - Wait low stretches the EPP cycle.
// - Initialise driven low, released when bit 1.
// - Data lines carry bytes both directions.
// - Select driven low, released when bit 0.
// - Address strobe low in address cycle, high on abort.
// - Byte strobe driven low, released when bit 0 outside the auto strobe state.
// - Write strobe low during EPP write cycles.
// - Write strobe returns high on abort.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pp_port (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic        ack_n,
  input  wire logic        busy_wait,
  input  wire logic        err_n,
  input  wire logic        paper_out,
  input  wire logic        peripheral_online,
  input  wire logic [7:0]  port_byte_lines_i,
  output logic      [7:0]  port_byte_lines_o,
  output logic             port_byte_lines_oe,
  output logic             auto_line_feed_n_o,
  output logic             auto_line_feed_n_oe,
  output logic             select_peripheral_n_o,
  output logic             select_peripheral_n_oe,
  output logic             byte_valid_strobe_n_o,
  output logic             byte_valid_strobe_n_oe,
  output logic             init_n_o,
  output logic             init_n_oe
);

  pp_pkg::pp_regs_t q;
  pp_pkg::pp_regs_t d;
  pp_pkg::pp_pins_t pin;
  logic [pp_pkg::PINS_W-1:0] pin_raw;
  logic [pp_pkg::PINS_W-1:0] pin_s;
  logic [pp_pkg::IRQ_W-1:0]  ev;
  logic [pp_pkg::IRQ_W-1:0]  w1c;
  logic                      epp;
  logic                      e_active;
  logic                      wr_data;
  logic                      wr_ctrl;
  logic                      wr_eaddr;
  logic                      wr_edata;
  logic                      wr_erd;
  logic                      abort;
  logic                      epp_epp_data_strobe;
  logic                      epp_epp_address_strobe;
  logic                      epp_write;

  // Pin inputs cross into the core domain
  assign pin_raw = {port_byte_lines_i, peripheral_online, paper_out, err_n, busy_wait, ack_n};

  pp_sync #(
    .W (pp_pkg::PINS_W)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (pin_raw),
    .dout     (pin_s)
  );

  assign pin = pin_s;

  assign epp      = q.ctrl[pp_pkg::CTRL_EPP];
  assign e_active = (q.st == pp_pkg::S_E_SETUP) || (q.st == pp_pkg::S_E_STROBE);
  assign wr_data  = reg_wr && (reg_addr == pp_pkg::REG_DATA);
  assign wr_ctrl  = reg_wr && (reg_addr == pp_pkg::REG_CTRL);
  assign wr_eaddr = reg_wr && (reg_addr == pp_pkg::REG_EPP_ADDR);
  assign wr_edata = reg_wr && (reg_addr == pp_pkg::REG_EPP_DATA);
  assign wr_erd   = reg_wr && (reg_addr == pp_pkg::REG_EPP_RD);
  assign abort    = wr_ctrl && reg_wdata[pp_pkg::CTRL_ABORT];
  assign w1c      = (reg_wr && (reg_addr == pp_pkg::REG_IRQ_ST)) ? reg_wdata[pp_pkg::IRQ_W-1:0] : '0;

  always_comb begin
    d          = q;
    ev         = '0;
    d.rdata    = 8'h00;
    d.ack_prev = pin.ack_n;
    d.err_prev = pin.err_n;
    // Peripheral events
    if (q.ack_prev && !pin.ack_n) begin
      ev[pp_pkg::IRQ_ACK] = 1'b1;
    end
    if (q.err_prev && !pin.err_n) begin
      ev[pp_pkg::IRQ_ERR] = 1'b1;
    end
    if (wr_ctrl) begin
      d.ctrl                   = reg_wdata[7:0];
      d.ctrl[pp_pkg::CTRL_ABORT] = 1'b0;
    end
    if (reg_wr && (reg_addr == pp_pkg::REG_IRQ_MASK)) begin
      d.irq_mask = reg_wdata[pp_pkg::IRQ_W-1:0];
    end
    // Compatibility bytes wait in a holding latch
    if (wr_data && !epp) begin
      d.pend   = reg_wdata[7:0];
      d.pend_v = 1'b1;
    end
    case (q.st)
      pp_pkg::S_IDLE: begin
        d.cnt = 10'h000;
        if (epp) begin
          if (wr_eaddr || wr_edata) begin
            d.dout     = reg_wdata[7:0];
            d.epp_wr   = 1'b1;
            d.epp_addr = wr_eaddr;
            d.st       = pp_pkg::S_E_SETUP;
          end else if (wr_erd) begin
            d.epp_wr   = 1'b0;
            d.epp_addr = reg_wdata[0];
            d.st       = pp_pkg::S_E_SETUP;
          end
        end else if (q.pend_v && !pin.busy_wait) begin
          d.dout   = q.pend;
          d.pend_v = wr_data && !epp;
          if (q.ctrl[pp_pkg::CTRL_AUTO]) begin
            d.st = pp_pkg::S_C_SETUP;
          end
        end
      end
      pp_pkg::S_C_SETUP: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt == pp_pkg::C_SETUP_CYC - 10'h001) begin
          d.cnt = 10'h000;
          d.st  = pp_pkg::S_C_STROBE;
        end
      end
      pp_pkg::S_C_STROBE: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt == pp_pkg::C_STROBE_CYC - 10'h001) begin
          d.cnt = 10'h000;
          d.st  = pp_pkg::S_C_HOLD;
        end
      end
      pp_pkg::S_C_HOLD: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt == pp_pkg::C_HOLD_CYC - 10'h001) begin
          d.cnt              = 10'h000;
          d.st               = pp_pkg::S_IDLE;
          ev[pp_pkg::IRQ_TX] = 1'b1;
        end
      end
      pp_pkg::S_E_SETUP: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt == pp_pkg::E_SETUP_CYC - 10'h001) begin
          d.cnt = 10'h000;
          d.st  = pp_pkg::S_E_STROBE;
        end
      end
      pp_pkg::S_E_STROBE: begin
        d.cnt = q.cnt + 10'h001;
        if (pin.busy_wait) begin
          d.cnt                 = 10'h000;
          d.st                  = pp_pkg::S_IDLE;
          ev[pp_pkg::IRQ_EDONE] = 1'b1;
          if (!q.epp_wr) begin
            d.epp_rd = pin.lines;
          end
        end else if (q.cnt == pp_pkg::E_TIMEOUT_CYC - 10'h001) begin
          d.cnt               = 10'h000;
          d.st                = pp_pkg::S_IDLE;
          ev[pp_pkg::IRQ_ETO] = 1'b1;
        end
      end
      default: begin
        d.cnt = 10'h000;
        d.st  = pp_pkg::S_IDLE;
      end
    endcase
    // Software abort ends any EPP cycle at once
    if (abort && e_active) begin
      d.cnt = 10'h000;
      d.st  = pp_pkg::S_IDLE;
    end
    // Set wins over clear
    d.irq_st = (q.irq_st & ~w1c) | ev;
    if (reg_rd) begin
      case (reg_addr)
        pp_pkg::REG_DATA: begin
          d.rdata = (q.ctrl[pp_pkg::CTRL_DIR] && !epp) ? pin.lines : q.dout;
        end
        pp_pkg::REG_PINS: begin
          d.rdata = {1'b0, e_active, q.pend_v, pin.online, pin.paper_out, pin.err_n, pin.busy_wait, pin.ack_n};
        end
        pp_pkg::REG_CTRL: begin
          d.rdata = q.ctrl;
        end
        pp_pkg::REG_EPP_RD: begin
          d.rdata = q.epp_rd;
        end
        pp_pkg::REG_IRQ_ST: begin
          d.rdata = {3'b000, q.irq_st};
        end
        pp_pkg::REG_IRQ_MASK: begin
          d.rdata = {3'b000, q.irq_mask};
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q          <= '0;
      q.st       <= pp_pkg::S_IDLE;
      q.ctrl     <= pp_pkg::CTRL_RST;
      q.ack_prev <= 1'b0;
      q.err_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // EPP strobes, active high; the pins carry them inverted
  assign epp_epp_data_strobe = (q.st == pp_pkg::S_E_STROBE) && !q.epp_addr;
  assign epp_epp_address_strobe = (q.st == pp_pkg::S_E_STROBE) && q.epp_addr;
  assign epp_write = e_active && q.epp_wr;

  always_comb begin
    if (epp) begin
      auto_line_feed_n_o     = !epp_epp_data_strobe;
      auto_line_feed_n_oe    = 1'b1;
      select_peripheral_n_o  = !epp_epp_address_strobe;
      select_peripheral_n_oe = 1'b1;
      byte_valid_strobe_n_o  = !epp_write;
      byte_valid_strobe_n_oe = 1'b1;
      port_byte_lines_oe     = epp_write;
    end else begin
      auto_line_feed_n_o     = 1'b0;
      auto_line_feed_n_oe    = q.ctrl[pp_pkg::CTRL_LF];
      select_peripheral_n_o  = 1'b0;
      select_peripheral_n_oe = q.ctrl[pp_pkg::CTRL_SEL];
      byte_valid_strobe_n_o  = 1'b0;
      byte_valid_strobe_n_oe = q.ctrl[pp_pkg::CTRL_STB] || (q.st == pp_pkg::S_C_STROBE);
      port_byte_lines_oe     = !q.ctrl[pp_pkg::CTRL_DIR];
    end
  end

  assign init_n_o          = 1'b0;
  assign init_n_oe         = !q.ctrl[pp_pkg::CTRL_INIT];
  assign port_byte_lines_o = q.dout;
  assign reg_rdata         = {24'h0000_00, q.rdata};
  assign irq               = |(q.irq_st & q.irq_mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_lf_release: assert property (
    wr_ctrl && !reg_wdata[pp_pkg::CTRL_LF] && !reg_wdata[pp_pkg::CTRL_EPP] |=> !auto_line_feed_n_oe)
    else $error("line feed not released");

  a_init_release: assert property (
    wr_ctrl && reg_wdata[pp_pkg::CTRL_INIT] |=> !init_n_oe [*2])
    else $error("initialise not released");

  a_init_drive: assert property (
    wr_ctrl && !reg_wdata[pp_pkg::CTRL_INIT] |=> init_n_oe && !init_n_o)
    else $error("initialise not driven low");

  a_sel_release: assert property (
    wr_ctrl && !reg_wdata[pp_pkg::CTRL_SEL] && !reg_wdata[pp_pkg::CTRL_EPP] |=> !select_peripheral_n_oe)
    else $error("select not released");

  a_stb_release: assert property (
    !epp && !q.ctrl[pp_pkg::CTRL_STB] && (q.st != pp_pkg::S_C_STROBE) |-> !byte_valid_strobe_n_oe)
    else $error("byte strobe not released");

  a_abort_strobes: assert property (
    abort && epp && e_active && reg_wdata[pp_pkg::CTRL_EPP] |=> auto_line_feed_n_o && select_peripheral_n_o)
    else $error("strobes active after abort");

  a_abort_write: assert property (
    abort && epp && e_active |=> byte_valid_strobe_n_o || !epp)
    else $error("write strobe active after abort");

  a_write_low: assert property (
    epp && q.epp_wr && (q.st == pp_pkg::S_E_STROBE) |-> !byte_valid_strobe_n_o && port_byte_lines_oe)
    else $error("write strobe high in write cycle");

  a_epp_address_strobe_cycle: assert property (
    epp && $rose(q.st == pp_pkg::S_E_STROBE) && q.epp_addr |-> !select_peripheral_n_o && auto_line_feed_n_o)
    else $error("address strobe wrong");

  a_wait_stretch: assert property (
    (q.st == pp_pkg::S_E_STROBE) && !pin.busy_wait && !abort && (q.cnt < pp_pkg::E_TIMEOUT_CYC - 10'h001)
    |=> (q.st == pp_pkg::S_E_STROBE))
    else $error("EPP cycle ended while wait asserted");

  a_busy_hold: assert property (
    !epp && pin.busy_wait && (q.st == pp_pkg::S_IDLE) && !$past(wr_ctrl) |=> $stable(q.dout))
    else $error("new character presented while busy");

  a_strobe_width: assert property (
    $rose(q.st == pp_pkg::S_C_STROBE) |-> (q.st == pp_pkg::S_C_STROBE) [*8])
    else $error("byte strobe too short");

  a_epp_data_strobe_cycle: assert property (
    epp && (q.st == pp_pkg::S_E_STROBE) && !q.epp_addr |-> !auto_line_feed_n_o && select_peripheral_n_o)
    else $error("data strobe wrong");

  a_read_float: assert property (
    epp && e_active && !q.epp_wr |-> !port_byte_lines_oe)
    else $error("data lines driven in read cycle");

  a_wait_limit: assert property (
    (q.st == pp_pkg::S_E_STROBE) && !pin.busy_wait && (q.cnt == pp_pkg::E_TIMEOUT_CYC - 10'h001)
    |=> (q.st == pp_pkg::S_IDLE) && q.irq_st[pp_pkg::IRQ_ETO])
    else $error("EPP timeout not flagged");

  a_ack_event: assert property (
    $fell(pin.ack_n) |=> q.irq_st[pp_pkg::IRQ_ACK])
    else $error("acknowledge edge not flagged");

  a_busy_start: assert property (
    !epp && pin.busy_wait && (q.st == pp_pkg::S_IDLE) |=> (q.st == pp_pkg::S_IDLE))
    else $error("strobe sequence started while busy");

  a_tx_done: assert property (
    (q.st == pp_pkg::S_C_HOLD) && (q.cnt == pp_pkg::C_HOLD_CYC - 10'h001)
    |=> (q.st == pp_pkg::S_IDLE) && q.irq_st[pp_pkg::IRQ_TX])
    else $error("byte done not flagged");

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> (reg_rdata == 32'h0000_0000))
    else $error("read data outside read slot");

endmodule
`default_nettype wire

// *** hw/unused_placeholder_none.sv ***
// Intentionally empty compile unit.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** tb/pp_periph.sv ***
// Behavioural printer and EPP peripheral facing the parallel host port.
// Assumes the bench resolves the pulled-up control lines and passes their levels.
`timescale 1ns/1ns
`default_nettype none
module pp_periph (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       epp,
  input  wire logic [7:0] delay,
  input  wire logic       hang,
  input  wire logic [7:0] rd_byte,
  input  wire logic       lf_l,
  input  wire logic       sel_l,
  input  wire logic       stb_l,
  input  wire logic [7:0] lines_o,
  input  wire logic       lines_oe,
  output logic      [7:0] lines_i,
  output logic            ack_n,
  output logic            busy_wait,
  output logic            got_v,
  output logic      [8:0] got,
  output logic            viol
);
  logic [7:0] cnt;
  logic [7:0] held;
  logic       armed;
  // Released lines show the inverse outside a strobe so stale data never passes
  assign lines_i = lines_oe ? lines_o : ((!lf_l || !sel_l) ? rd_byte : ~rd_byte);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      held <= 8'h00;
      armed <= 1'b0;
      ack_n <= 1'b1;
      busy_wait <= 1'b0;
      got_v <= 1'b0;
      got <= 9'h000;
      viol <= 1'b0;
    end else begin
      got_v <= 1'b0;
      ack_n <= 1'b1;
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      if (!epp) begin
        if (!stb_l && !busy_wait) begin
          busy_wait <= 1'b1;
          held <= lines_i;
          cnt <= delay;
          got_v <= 1'b1;
          got <= {1'b0, lines_i};
        end else if (busy_wait && cnt == 8'h01) begin
          ack_n <= 1'b0;
          busy_wait <= 1'b0;
        end
        if (busy_wait && lines_oe && lines_o != held) viol <= 1'b1;
      end else if (!lf_l || !sel_l) begin
        if (!armed) begin
          armed <= 1'b1;
          cnt <= delay;
        end else if (cnt == 8'h01 && !hang) begin
          busy_wait <= 1'b1;
          got_v <= !stb_l;
          got <= {!sel_l, lines_i};
        end
      end else begin
        armed <= 1'b0;
        busy_wait <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/pp_port_test.sv ***
// Self-checking bench for the parallel host port.
// Assumes pp_pkg, pp_port and the peripheral model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pp_port_test;
  logic        core_clk, resetn, reg_wr, reg_rd, epp, hang, err_n, paper_out, online, rd_seen;
  logic [7:0]  reg_addr, delay, rd_byte;
  logic [31:0] reg_wdata, seed, r;
  int          miscompares, cmp_count;
  logic [31:0] rd_q[$];
  logic [8:0]  byte_q[$];
  wire logic [31:0] reg_rdata;
  wire logic [8:0]  got;
  wire logic [7:0]  lo, li;
  wire logic irq, ack_n, busy_wait, loe, lf_o, lf_oe, sel_o, sel_oe, stb_o, stb_oe, in_o, in_oe, got_v, viol;
  wire logic lf_l = lf_oe ? lf_o : 1'b1;
  wire logic sel_l = sel_oe ? sel_o : 1'b1;
  wire logic stb_l = stb_oe ? stb_o : 1'b1;
  wire logic in_l = in_oe ? in_o : 1'b1;

  pp_port dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .ack_n(ack_n), .busy_wait(busy_wait),
    .err_n(err_n), .paper_out(paper_out), .peripheral_online(online), .port_byte_lines_i(li),
    .port_byte_lines_o(lo), .port_byte_lines_oe(loe), .auto_line_feed_n_o(lf_o), .auto_line_feed_n_oe(lf_oe),
    .select_peripheral_n_o(sel_o), .select_peripheral_n_oe(sel_oe), .byte_valid_strobe_n_o(stb_o),
    .byte_valid_strobe_n_oe(stb_oe), .init_n_o(in_o), .init_n_oe(in_oe));
  pp_periph per (.core_clk(core_clk), .resetn(resetn), .epp(epp), .delay(delay), .hang(hang),
    .rd_byte(rd_byte), .lf_l(lf_l), .sel_l(sel_l), .stb_l(stb_l), .lines_o(lo), .lines_oe(loe),
    .lines_i(li), .ack_n(ack_n), .busy_wait(busy_wait), .got_v(got_v), .got(got), .viol(viol));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_byte(input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD peripheral byte expected %h seen %h", e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_irq;
    int i;
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge core_clk);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(pp_pkg::REG_IRQ_ST, 32'h0000_001f);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen && rd_q.size() > 0) chk("read data", rd_q.pop_front(), reg_rdata);
    if (got_v && byte_q.size() > 0) chk_byte(byte_q.pop_front(), got);
    else if (got_v) chk_byte(9'h1ff, got);
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    end_of_test;
  end

  initial begin
    {resetn, reg_wr, reg_rd, epp, hang, reg_addr, reg_wdata, rd_byte} = '0;
    {err_n, paper_out, online} = 3'b101;
    delay = 8'd120;
    seed = 32'h48b8_57e6;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd(pp_pkg::REG_CTRL, 32'h0000_0004);
    for (int v = 0; v < 16; v++) begin
      if (v == 1) byte_q.push_back(9'h000);
      wr(pp_pkg::REG_CTRL, v);
      #1;
      chk("line feed", !v[1], lf_l);
      chk("select", !v[3], sel_l);
      chk("byte strobe", !v[0], stb_l);
      chk("init drive", !v[2], in_oe);
      chk("init level", v[2], in_l);
    end
    wr(pp_pkg::REG_CTRL, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    chk("data drive", 32'h0, loe);
    rd(pp_pkg::REG_DATA, 32'h0000_00ff);
    $display("control lines done");
    wr(pp_pkg::REG_IRQ_MASK, 32'h0000_0004);
    wr(pp_pkg::REG_CTRL, 32'h0000_0044);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      byte_q.push_back({1'b0, r[7:0]});
      wr(pp_pkg::REG_DATA, r[7:0]);
      wait_irq;
    end
    repeat (100) @(posedge core_clk);
    rd(pp_pkg::REG_IRQ_ST, 32'h0000_0001);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(pp_pkg::REG_IRQ_MASK, 32'h0000_0001);
    #1;
    chk("unmasked irq", 32'h1, {31'h0, irq});
    wr(pp_pkg::REG_IRQ_ST, 32'h0000_0001);
    #1;
    chk("cleared irq", 32'h0, {31'h0, irq});
    $display("print done");
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      @(posedge core_clk);
      {online, paper_out, err_n} <= r[2:0];
      repeat (4) @(posedge core_clk);
      rd(pp_pkg::REG_PINS, {27'h0, r[2:0], 2'b01});
    end
    @(posedge core_clk);
    err_n <= 1'b1;
    wr(pp_pkg::REG_IRQ_ST, 32'h0000_001f);
    err_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(pp_pkg::REG_IRQ_ST, 32'h0000_0002);
    $display("status pins done");
    epp <= 1'b1;
    wr(pp_pkg::REG_CTRL, 32'h0000_0024);
    wr(pp_pkg::REG_IRQ_MASK, 32'h0000_0008);
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      delay <= {2'b0, r[13:8]} + 8'd2;
      rd_byte <= r[7:0];
      if (k < 4) byte_q.push_back({k[0], r[7:0]});
      if (k < 4) wr(k[0] ? pp_pkg::REG_EPP_ADDR : pp_pkg::REG_EPP_DATA, r[7:0]);
      else wr(pp_pkg::REG_EPP_RD, k[0]);
      wait_irq;
      if (k >= 4) rd(pp_pkg::REG_EPP_RD, r[7:0]);
    end
    hang <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(k[0] ? pp_pkg::REG_EPP_ADDR : pp_pkg::REG_EPP_DATA, 32'h0000_005a);
      repeat (60) @(posedge core_clk);
      #1;
      chk("held strobe", 32'h0, k[0] ? sel_l : lf_l);
      chk("write strobe", 32'h0, stb_l);
      wr(pp_pkg::REG_CTRL, 32'h0000_00a4);
      repeat (2) @(posedge core_clk);
      #1;
      chk("data strobe", 32'h1, lf_l);
      chk("address strobe", 32'h1, sel_l);
      chk("write strobe", 32'h1, stb_l);
    end
    wr(pp_pkg::REG_IRQ_MASK, 32'h0000_0010);
    wr(pp_pkg::REG_EPP_DATA, 32'h0000_00a5);
    wait_irq;
    #1;
    chk("timeout data strobe", 32'h1, lf_l);
    chk("timeout write strobe", 32'h1, stb_l);
    $display("epp done");
    chk("busy overrun", 32'h0, viol);
    chk("bytes left", 32'h0, byte_q.size());
    end_of_test;
  end
endmodule
`default_nettype wire
